// ---- sram_ctrl_pkg.sv ----
/*
 * constants and carrier types for the host-side controller of an
 * asynchronous 1 M x 16 static memory.
 * assumes a 10 MHz system clock; all pin timing is counted in its cycles.
 */
package sram_ctrl_pkg;

    localparam int ADDR_W  = 20;
    localparam int DATA_W  = 16;
    localparam int CLK_NS  = 100;

    // speed grade figures, slow grade taken so one build fits both parts
    localparam int T_CYCLE_NS  = 55;
    localparam int T_AW_NS     = 50;
    localparam int T_CW_NS     = 50;
    localparam int T_WP_NS     = 40;
    localparam int T_DW_NS     = 25;
    localparam int T_OE_NS     = 35;
    localparam int T_AS_NS     = 0;
    localparam int T_WR_NS     = 0;

    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int WP_CYC   = cyc_min(T_WP_NS > T_CW_NS ? T_WP_NS : T_CW_NS);
    localparam int RD_CYC   = cyc_min(T_CYCLE_NS > T_OE_NS ? T_CYCLE_NS : T_OE_NS);
    localparam int CNT_W    = 4;
    localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(WP_CYC);
    localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);

    localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    typedef struct packed {
        logic              write;
        logic [1:0]        lane_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_t;

    typedef struct packed {
        logic              select_active_low;
        logic              select_active_high;
        logic              write_n;
        logic              out_gate_n;
        logic              lower_lane_select_n;
        logic              upper_lane_select_n;
        logic [ADDR_W-1:0] word_address;
    } pins_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_WRITE = 5'b00100,
        ST_READ  = 5'b01000,
        ST_END   = 5'b10000
    } state_t;

endpackage

// ---- sram_host_ctrl.sv ----
/*
 * host-side controller driving an asynchronous 1 M x 16 static memory
 * with single read and write word or byte accesses, plus a retention request.
 * assumes pins are sampled synchronous to clk and the memory is wired directly.
 */
// Notes on behaviour
// - one shared bus; memory drives only on reads, host only on writes.
// - write happens while both selects active, strobe low, a lane selected.
// - address valid at least 45 or 50 ns before write ends.
// - both selects active at least 45 or 50 ns before write ends.
// - address valid no later than write start, 0 ns setup.
// - address held at least 0 ns after the write ends.
// - write data valid 25 ns before write end, held 0 ns after.
// - write pulse lasts at least 35 or 40 ns.
// - active-high select retention keeps data with other inputs floating.
// - active-low select retention needs active-high select held at a rail.
// - deselect before supply drops into retention, 0 ns minimum.
`timescale 1ns/1ps
module sram_host_ctrl (
    input  wire logic                                  clk,
    input  wire logic                                  reset_n,
    input  wire logic                                  req_valid,
    input  wire sram_ctrl_pkg::req_t                   req,
    input  wire logic                                  retain_req,
    output logic                                       req_ready,
    output logic                                       rsp_valid,
    output logic      [sram_ctrl_pkg::DATA_W-1:0]      rsp_rdata,
    output logic                                       retain_ok,
    output sram_ctrl_pkg::pins_t                       pins,
    input  wire logic [sram_ctrl_pkg::DATA_W-1:0]      shared_data_lines_in,
    output logic      [sram_ctrl_pkg::DATA_W-1:0]      shared_data_lines_out,
    output logic      [sram_ctrl_pkg::DATA_W-1:0]      shared_data_lines_oe,
    output logic                                       factory_test_pin
);
    typedef struct packed {
        sram_ctrl_pkg::state_t                     st;
        logic [sram_ctrl_pkg::CNT_W-1:0]           cnt;
        sram_ctrl_pkg::req_t                       cur;
        sram_ctrl_pkg::pins_t                      pins;
        logic                                      ready;
        logic                                      rvalid;
        logic [sram_ctrl_pkg::DATA_W-1:0]          rdata;
        logic                                      retained;
        logic                                      drive;
    } state_s_t;

    state_s_t s_q;
    state_s_t s_d;

    logic [sram_ctrl_pkg::DATA_W-1:0] rd_lane;

    // a lane that was not asked for reads as zero, never as whatever floats there
    for (genvar g = 0; g < 2; g++) begin : g_rd_lane
        assign rd_lane[g*8 +: 8] = s_q.cur.lane_en[g] ? shared_data_lines_in[g*8 +: 8] : 8'h00;
    end

    always_comb begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        case (s_q.st)
            sram_ctrl_pkg::ST_IDLE: begin
                // idle: active-low select off keeps memory in standby, lines released
                s_d.pins.select_active_low  = 1'b1;
                s_d.pins.out_gate_n         = 1'b1;
                s_d.pins.write_n            = 1'b1;
                s_d.drive                   = 1'b0;
                if (retain_req) begin
                    // hold active-high select low: inputs may float safely
                    // deselect happens before retention is granted
                    s_d.pins.select_active_high = 1'b0;
                    s_d.retained                = s_q.pins.select_active_high == 1'b0;
                    s_d.ready                   = 1'b0;
                end else begin
                    s_d.retained                = 1'b0;
                    s_d.pins.select_active_high = 1'b1;
                    s_d.ready                   = 1'b1;
                    if (req_valid && s_q.ready && (req.lane_en != 2'b00)) begin
                        s_d.cur   = req;
                        s_d.ready = 1'b0;
                        // address and lanes settle a cycle before any strobe
                        s_d.pins.word_address        = req.addr;
                        s_d.pins.lower_lane_select_n = ~req.lane_en[0];
                        s_d.pins.upper_lane_select_n = ~req.lane_en[1];
                        s_d.pins.select_active_low   = 1'b0;
                        s_d.drive                    = req.write;
                        s_d.st                       = sram_ctrl_pkg::ST_SETUP;
                    end
                end
            end
            sram_ctrl_pkg::ST_SETUP: begin
                s_d.cnt = '0;
                if (s_q.cur.write) begin
                    // strobe is the last qualifying edge, so it starts the write
                    s_d.pins.write_n = 1'b0;
                    s_d.st           = sram_ctrl_pkg::ST_WRITE;
                end else begin
                    // read: strobe stays high, gate falls
                    s_d.pins.out_gate_n = 1'b0;
                    s_d.st              = sram_ctrl_pkg::ST_READ;
                end
            end
            sram_ctrl_pkg::ST_WRITE: begin
                s_d.cnt = s_q.cnt + 1'b1;
                // one 100 ns cycle covers pulse, select and address windows
                if (s_q.cnt + 1'b1 >= sram_ctrl_pkg::WP_CNT) begin
                    // strobe rises first, so it ends the write
                    s_d.pins.write_n = 1'b1;
                    s_d.st           = sram_ctrl_pkg::ST_END;
                end
            end
            sram_ctrl_pkg::ST_READ: begin
                s_d.cnt = s_q.cnt + 1'b1;
                // sample after gate low long enough for valid data
                if (s_q.cnt + 1'b1 >= sram_ctrl_pkg::RD_CNT) begin
                    s_d.rdata           = rd_lane;
                    s_d.rvalid          = 1'b1;
                    s_d.pins.out_gate_n = 1'b1;
                    s_d.st              = sram_ctrl_pkg::ST_END;
                end
            end
            sram_ctrl_pkg::ST_END: begin
                // address and data held one cycle after the strobe rises
                s_d.drive                   = 1'b0;
                s_d.pins.select_active_low  = 1'b1;
                s_d.pins.lower_lane_select_n = 1'b1;
                s_d.pins.upper_lane_select_n = 1'b1;
                s_d.ready                   = ~retain_req;
                s_d.st                      = sram_ctrl_pkg::ST_IDLE;
            end
            default: begin
                s_d.st = sram_ctrl_pkg::ST_IDLE;
            end
        endcase
        if (!reset_n) begin
            s_d.st                       = sram_ctrl_pkg::ST_IDLE;
            s_d.cnt                      = '0;
            s_d.cur                      = '0;
            s_d.ready                    = 1'b0;
            s_d.rvalid                   = 1'b0;
            s_d.rdata                    = sram_ctrl_pkg::DATA_RST;
            s_d.retained                 = 1'b0;
            s_d.drive                    = 1'b0;
            s_d.pins.select_active_low   = 1'b1;
            s_d.pins.select_active_high  = 1'b0;
            s_d.pins.write_n             = 1'b1;
            s_d.pins.out_gate_n          = 1'b1;
            s_d.pins.lower_lane_select_n = 1'b1;
            s_d.pins.upper_lane_select_n = 1'b1;
            s_d.pins.word_address        = sram_ctrl_pkg::ADDR_RST;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    // data drive is registered in step with the strobes
    sram_lane_drv u_drv (
        .clk      (clk),
        .reset_n  (reset_n),
        .drive    (s_d.drive),
        .lane_en  (s_d.cur.lane_en),
        .wdata    (s_d.cur.wdata),
        .data_out (shared_data_lines_out),
        .data_oe  (shared_data_lines_oe)
    );

    logic test_pin_q;
    always_ff @(posedge clk) begin
        test_pin_q <= 1'b0;
    end

    assign req_ready        = s_q.ready;
    assign rsp_valid        = s_q.rvalid;
    assign rsp_rdata        = s_q.rdata;
    assign retain_ok        = s_q.retained;
    assign pins             = s_q.pins;
    assign factory_test_pin = test_pin_q;
endmodule

// ---- sram_host_ctrl_asserts.sv ----
/*
 * pin-level checks for the host controller of the static memory.
 * assumes the single clk domain and bind onto sram_host_ctrl by port names.
 */
`timescale 1ns/1ps
module sram_host_ctrl_asserts (
    input wire logic                             clk,
    input wire logic                             reset_n,
    input wire logic                             rsp_valid,
    input wire logic [sram_ctrl_pkg::DATA_W-1:0] rsp_rdata,
    input wire logic                             retain_ok,
    input wire sram_ctrl_pkg::pins_t             pins,
    input wire logic [sram_ctrl_pkg::DATA_W-1:0] shared_data_lines_in,
    input wire logic [sram_ctrl_pkg::DATA_W-1:0] shared_data_lines_out,
    input wire logic [sram_ctrl_pkg::DATA_W-1:0] shared_data_lines_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_WR_QUAL: assert property (!pins.write_n |-> !pins.select_active_low &&
        pins.select_active_high && !(pins.lower_lane_select_n && pins.upper_lane_select_n))
        else $error("write strobe low without a full select");
    AST_WP: assert property ($fell(pins.write_n) |=> pins.write_n &&
        !pins.select_active_low ##1 pins.select_active_low) else $error("write pulse shape");
    AST_ADDR: assert property ($fell(pins.write_n) |=>
        $stable(pins.word_address) [*2]) else $error("address moved around a write");
    AST_CS: assert property ($fell(pins.write_n) |->
        $past(!pins.select_active_low && pins.select_active_high))
        else $error("select not set up before write");
    AST_DATA: assert property (!pins.write_n |-> $stable(shared_data_lines_out) &&
        shared_data_lines_oe == {{8{!pins.upper_lane_select_n}}, {8{!pins.lower_lane_select_n}}})
        else $error("write data not held on its lanes");
    AST_BUS: assert property (shared_data_lines_oe != 16'h0000 |->
        pins.out_gate_n && !pins.select_active_low) else $error("host drives outside a write");
    AST_GATE: assert property (!pins.out_gate_n |-> pins.write_n &&
        shared_data_lines_oe == 16'h0000) else $error("gate low during a write");
    AST_RD: assert property ($fell(pins.out_gate_n) |=> rsp_valid &&
        pins.out_gate_n) else $error("read data not taken after gate");
    AST_LANE: assert property (rsp_valid |-> rsp_rdata == {
        $past(pins.upper_lane_select_n) ? 8'h00 : $past(shared_data_lines_in[15:8]),
        $past(pins.lower_lane_select_n) ? 8'h00 : $past(shared_data_lines_in[7:0])})
        else $error("read lanes wrong");
    AST_RET: assert property (retain_ok |-> !pins.select_active_high &&
        $past(!pins.select_active_high)) else $error("retention without deselect");
    COV_WR: cover property ($fell(pins.write_n));
    COV_RD: cover property (rsp_valid);
    COV_RET: cover property ($rose(retain_ok));
endmodule
bind sram_host_ctrl sram_host_ctrl_asserts i_chk (.clk, .reset_n, .rsp_valid, .rsp_rdata,
    .retain_ok, .pins, .shared_data_lines_in, .shared_data_lines_out, .shared_data_lines_oe);

// ---- sram_lane_drv.sv ----
/*
 * per-lane data driver toward the shared data lines.
 * assumes the main controller decides when a write is active.
 */
`timescale 1ns/1ps
module sram_lane_drv (
    input  wire logic                                  clk,
    input  wire logic                                  reset_n,
    input  wire logic                                  drive,
    input  wire logic [1:0]                            lane_en,
    input  wire logic [sram_ctrl_pkg::DATA_W-1:0]      wdata,
    output logic      [sram_ctrl_pkg::DATA_W-1:0]      data_out,
    output logic      [sram_ctrl_pkg::DATA_W-1:0]      data_oe
);
    typedef struct packed {
        logic [sram_ctrl_pkg::DATA_W-1:0] dout;
        logic [sram_ctrl_pkg::DATA_W-1:0] oe;
    } drv_t;

    drv_t s_q;
    drv_t s_d;

    always_comb begin
        s_d.dout = wdata;
        s_d.oe   = '0;
        for (int l = 0; l < 2; l++) begin
            // only selected lanes are driven, only during a write
            s_d.oe[l*8 +: 8] = {8{drive & lane_en[l]}};
        end
        if (!reset_n) begin
            s_d.dout = sram_ctrl_pkg::DATA_RST;
            s_d.oe   = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign data_out = s_q.dout;
    assign data_oe  = s_q.oe;
endmodule

// ---- sram_mem_model.sv ----
/*
 * behavioural 1 M x 16 static memory on the far side of the controller.
 * assumes the bench resolves the shared lines and feeds the level back.
 */
`timescale 1ns/1ps
module sram_mem_model (
    input  wire sram_ctrl_pkg::pins_t pins,
    input  wire logic [15:0]          bus_level,
    output logic      [15:0]          mem_lines
);
    // two-state store: cells never written read as zero, not as unknown
    bit   [15:0] mem [0:20'hfffff];
    logic        sel;
    logic        wr_act;
    logic        rd_act;
    logic [1:0]  lanes_q = 2'b00;
    logic [15:0] word;
    assign sel = !pins.select_active_low && pins.select_active_high;
    assign wr_act = sel && !pins.write_n &&
        !(pins.lower_lane_select_n && pins.upper_lane_select_n);
    assign rd_act = sel && pins.write_n && !pins.out_gate_n;
    always @(pins or wr_act) begin
        if (wr_act)
            lanes_q = {!pins.upper_lane_select_n, !pins.lower_lane_select_n};
        word = mem[pins.word_address];
    end
    // stored at the end of the write, only selected lanes change
    always @(negedge wr_act) begin
        mem[pins.word_address] = (word & ~{{8{lanes_q[1]}}, {8{lanes_q[0]}}}) |
            (bus_level & {{8{lanes_q[1]}}, {8{lanes_q[0]}}});
    end
    // undriven lanes show the inverse word so a float never passes for data
    assign #35 mem_lines = {(rd_act && !pins.upper_lane_select_n) ? word[15:8] : ~word[15:8],
        (rd_act && !pins.lower_lane_select_n) ? word[7:0] : ~word[7:0]};
endmodule

// ---- tb_top.sv ----
/*
 * self-checking bench for sram_host_ctrl against the memory model.
 * assumes the package and the checker bind are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    logic                 clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 req_valid = 1'b0;
    sram_ctrl_pkg::req_t  req = '0;
    logic                 retain_req = 1'b0;
    logic                 req_ready, rsp_valid, retain_ok, test_pin;
    logic [15:0]          rsp_rdata, d_out, d_oe, d_in, mem_lines, q;
    sram_ctrl_pkg::pins_t pins;
    int                   fails = 0;
    int                   checks_done = 0;
    always #50 clk = ~clk;
    assign d_in = (d_out & d_oe) | (mem_lines & ~d_oe);
    sram_host_ctrl i_dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
        .retain_req(retain_req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .retain_ok(retain_ok), .pins(pins),
        .shared_data_lines_in(d_in), .shared_data_lines_out(d_out),
        .shared_data_lines_oe(d_oe), .factory_test_pin(test_pin));
    sram_mem_model i_mem (.pins(pins), .bus_level(d_in), .mem_lines(mem_lines));
    task automatic print_verdict();
        if (fails == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one request held until taken, then waits for the answer
    task automatic do_req(input logic w, input logic [1:0] ln, input logic [19:0] a,
                          input logic [15:0] d, output logic [15:0] rd);
        int n;
        n = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req = '{write: w, lane_en: ln, addr: a, wdata: d};
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        rd = 16'hxxxx;
        while (req_ready !== 1'b1 && n < 40) begin
            if (rsp_valid === 1'b1)
                rd = rsp_rdata;
            @(negedge clk);
            n++;
        end
        if (n >= 40)
            chk(16'hdead, 16'h0000);
    endtask
    task automatic t_idle();
        chk({pins.select_active_high, pins.select_active_low, test_pin}, 16'h0002);
        chk(d_oe, 16'h0000);
    endtask
    task automatic t_word();
        do_req(1'b1, 2'b11, 20'hfffff, 16'ha5c3, q);
        do_req(1'b1, 2'b11, 20'h00000, 16'h1234, q);
        do_req(1'b0, 2'b11, 20'hfffff, 16'h0000, q);
        chk(q, 16'ha5c3);
        do_req(1'b0, 2'b11, 20'h00000, 16'h0000, q);
        chk(q, 16'h1234);
    endtask
    task automatic t_lanes();
        do_req(1'b1, 2'b10, 20'hfffff, 16'h7e11, q);
        do_req(1'b0, 2'b01, 20'hfffff, 16'h0000, q);
        chk(q, 16'h00c3);
        do_req(1'b0, 2'b10, 20'hfffff, 16'h0000, q);
        chk(q, 16'h7e00);
        do_req(1'b1, 2'b01, 20'h00000, 16'hff56, q);
        do_req(1'b0, 2'b11, 20'h00000, 16'h0000, q);
        chk(q, 16'h1256);
    endtask
    task automatic t_refuse();
        @(negedge clk);
        req_valid = 1'b1;
        req = '{write: 1'b1, lane_en: 2'b00, addr: 20'h00000, wdata: 16'hffff};
        repeat (3) @(negedge clk);
        chk({req_ready, pins.select_active_low, pins.write_n}, 16'h0007);
        req_valid = 1'b0;
    endtask
    task automatic t_retain();
        @(negedge clk);
        retain_req = 1'b1;
        repeat (2) @(negedge clk);
        chk({retain_ok, pins.select_active_high}, 16'h0002);
        req_valid = 1'b1;
        req = '{write: 1'b1, lane_en: 2'b11, addr: 20'hfffff, wdata: 16'h0000};
        repeat (3) @(negedge clk);
        chk({req_ready, pins.write_n}, 16'h0001);
        req_valid = 1'b0;
        retain_req = 1'b0;
        repeat (2) @(negedge clk);
        do_req(1'b0, 2'b11, 20'hfffff, 16'h0000, q);
        chk(q, 16'h7ec3);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        t_idle();
        reset_n = 1'b1;
        t_word();
        t_lanes();
        t_refuse();
        t_retain();
        print_verdict();
    end
    // the whole sequence needs well under 200 cycles
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
endmodule
